// *** src/adss_pkg.sv ***
// Purpose: shared constants and types for the converter setup sequencer
// Assumes: 32-bit AHB-Lite register word per register
// Notes: offsets are byte addresses
package adss_pkg;
  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] CHANSEL_OFF = 8'h00;
  localparam logic [7:0] PINCFG_OFF = 8'h04;
  localparam logic [7:0] P2DIR_OFF = 8'h08;
  localparam logic [7:0] P15DIR_OFF = 8'h0C;
  localparam logic [7:0] MODE_OFF = 8'h10;
  localparam logic [7:0] REFCTL_OFF = 8'h14;
  localparam logic [7:0] RESULT_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1C;
  localparam logic [7:0] IRQSTAT_OFF = 8'h20;
  localparam logic [7:0] IRQMASK_OFF = 8'h24;
  localparam logic [7:0] PORTDATA_OFF = 8'h28;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int MODE_CS_BIT = 7;   // conversion start
  localparam int MODE_CE_BIT = 0;   // comparator enable
  localparam int MODE_LVL_BIT = 1;  // voltage mode low
  localparam int MODE_LVH_BIT = 2;  // voltage mode high
  localparam int MODE_FR_LSB = 3;   // time select, 3 bits
  localparam int REF_BOOST_BIT = 0; // input gate boost enable
  localparam int REF_AMP_BIT = 1;   // amplifier in use
  localparam int IRQ_END_BIT = 0;   // conversion end
  localparam int IRQ_ERR_BIT = 1;   // start refused on illegal setup
  localparam int NUM_CH = 8;
  localparam logic [7:0] AMP_CH = 8'h08; // amplifier output channel
  // -------------------------------------------------------------------
  // reset values and timing
  // -------------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;   // all pins input
  localparam int CLK_MHZ = 100;
  localparam int BASE_CONV_CYC = 16;        // cycles per time step
  localparam int OVERHEAD_CYC = 4;          // setup beyond selected time
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef struct packed {
    logic [2:0] time_sel;
    logic voltage_mode_high;
    logic voltage_mode_low;
  } adss_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_CONV = 3'b100
  } adss_state_t;
endpackage : adss_pkg

// *** src/adss_core.sv ***
// Purpose: conversion timing engine of the sequencer
// Assumes: start is a one-cycle pulse, mode held during conversion
// Notes: result is a deterministic stand-in for the analog sample
`timescale 1ns/100ps
`default_nettype none
module adss_core #(
  parameter int RES_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire adss_pkg::adss_mode_t mode,
  input wire logic [RES_W-1:0] sample,
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] result
);
  import adss_pkg::*;

  adss_state_t state_r, state_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic done_r, done_nxt;

  // conversion length from the time-select and voltage-mode fields
  function automatic logic [9:0] conv_len(input adss_mode_t m);
    conv_len = 10'((m.time_sel + 10'd1) * BASE_CONV_CYC
               + {m.voltage_mode_high, m.voltage_mode_low} * BASE_CONV_CYC);
  endfunction : conv_len

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  // next-state: setup phase makes start-to-end longer than the time
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SETUP;
          cnt_nxt = 10'(OVERHEAD_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_r == 10'd0) begin
          state_nxt = ST_CONV;
          cnt_nxt = conv_len(mode) - 10'd1;
        end else begin
          cnt_nxt = cnt_r - 10'd1;
        end
      end
      ST_CONV: begin
        if (cnt_r == 10'd0) begin
          state_nxt = ST_IDLE;
          res_nxt = sample;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 10'd1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 10'd0;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (state_r != ST_IDLE);
  assign done = done_r;
  assign result = res_r;
endmodule : adss_core
`default_nettype wire

// *** src/adss_top.sv ***
// Purpose: AHB-Lite register front and setup checks of the converter
// Assumes: single word transfers, zero wait states
// Notes: analog front end is modelled by the sample inputs
`timescale 1ns/100ps
`default_nettype none
module adss_top #(
  parameter int RES_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pin_level,
  input wire logic [RES_W-1:0] analog_sample,
  output logic irq,
  output logic [7:0] pin_analog_en,
  output logic boost_en
);
  import adss_pkg::*;

  initial begin
    if (RES_W < 1 || RES_W > 32) $error("RES_W must be 1..32");
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [7:0] channel_select_reg_r, channel_select_reg_nxt;
  logic [7:0] pin_analog_config_reg_r, pin_analog_config_reg_nxt;
  logic [7:0] port2_direction_reg_r, port2_direction_reg_nxt;
  logic [7:0] port15_direction_reg_r, port15_direction_reg_nxt;
  logic [7:0] converter_mode_reg_r, converter_mode_reg_nxt;
  logic [7:0] reference_control_reg_r, reference_control_reg_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic [RES_W-1:0] result_r, result_nxt;
  logic first_discard_r, first_discard_nxt;
  logic [7:0] ph_addr_r;
  logic ph_wr_r;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic irq_r;
  logic [7:0] pin_sync1_r, pin_sync2_r;

  logic core_busy, core_done, start_pulse, start_ok;
  logic [RES_W-1:0] core_result;
  logic addr_take;
  adss_mode_t mode_fields;

  assign mode_fields = '{time_sel: converter_mode_reg_r[MODE_FR_LSB +: 3],
                         voltage_mode_high: converter_mode_reg_r[MODE_LVH_BIT],
                         voltage_mode_low: converter_mode_reg_r[MODE_LVL_BIT]};

  // true where an analog role is available for a channel
  function automatic logic chan_analog(input logic [7:0] ch,
                                       input logic [7:0] cfg,
                                       input logic amp);
    chan_analog = 1'b0;
    if (ch == AMP_CH) chan_analog = amp;
    else if (ch < 8'(NUM_CH)) chan_analog = cfg[ch[2:0]];
  endfunction : chan_analog

  // pin levels come from outside, two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync1_r <= 8'h00;
      pin_sync2_r <= 8'h00;
    end else begin
      pin_sync1_r <= pin_level;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // -------------------------------------------------------------------
  // bus address phase
  // -------------------------------------------------------------------
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_addr_r <= 8'hFF;
      ph_wr_r <= 1'b0;
    end else begin
      ph_addr_r <= addr_take ? haddr[7:0] : 8'hFF;
      ph_wr_r <= addr_take && hwrite;
    end
  end

  // start is allowed only when boost is on for the reduced voltage
  // modes already held in the mode register and the chosen channel really carries an analog input
  // the comparator step may be skipped: enable and start in one write
  assign start_ok = !core_busy
    && (converter_mode_reg_r[MODE_CE_BIT] || hwdata[MODE_CE_BIT])
    && (!(mode_fields.voltage_mode_high ^ mode_fields.voltage_mode_low)
        || reference_control_reg_r[REF_BOOST_BIT])
    && chan_analog(channel_select_reg_r, pin_analog_config_reg_r,
                   reference_control_reg_r[REF_AMP_BIT]);
  assign start_pulse = ph_wr_r && (ph_addr_r == MODE_OFF)
                       && hwdata[MODE_CS_BIT];

  // -------------------------------------------------------------------
  // register write and event next values
  // -------------------------------------------------------------------
  always_comb begin
    channel_select_reg_nxt = channel_select_reg_r;
    pin_analog_config_reg_nxt = pin_analog_config_reg_r;
    port2_direction_reg_nxt = port2_direction_reg_r;
    port15_direction_reg_nxt = port15_direction_reg_r;
    converter_mode_reg_nxt = converter_mode_reg_r;
    reference_control_reg_nxt = reference_control_reg_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    result_nxt = result_r;
    first_discard_nxt = first_discard_r;
    if (ph_wr_r) begin
      case (ph_addr_r)
        CHANSEL_OFF: channel_select_reg_nxt = {4'h0, hwdata[3:0]};
        PINCFG_OFF: pin_analog_config_reg_nxt = hwdata[7:0];
        P2DIR_OFF: port2_direction_reg_nxt = hwdata[7:0];
        P15DIR_OFF: port15_direction_reg_nxt = hwdata[7:0];
        MODE_OFF: begin
          converter_mode_reg_nxt = hwdata[7:0];
          converter_mode_reg_nxt[MODE_CS_BIT] = 1'b0;
          // comparator enabled at start itself: step skipped
          if (hwdata[MODE_CE_BIT] && !converter_mode_reg_r[MODE_CE_BIT]
              && hwdata[MODE_CS_BIT] && start_ok)
            first_discard_nxt = 1'b1;
          if (core_busy) // hold mode fields mid conversion
            converter_mode_reg_nxt = converter_mode_reg_r;
        end
        REFCTL_OFF: begin
          if (!core_busy)
            reference_control_reg_nxt = hwdata[7:0];
        end
        IRQSTAT_OFF: irq_stat_nxt = irq_stat_r & ~hwdata[1:0];
        IRQMASK_OFF: irq_mask_nxt = hwdata[1:0];
        default: irq_mask_nxt = irq_mask_r;
      endcase
    end
    if (start_pulse && !start_ok)
      irq_stat_nxt[IRQ_ERR_BIT] = 1'b1; // set wins over clear
    if (core_done) begin
      if (first_discard_r) begin
        first_discard_nxt = 1'b0;
      end else begin
        result_nxt = core_result;
        irq_stat_nxt[IRQ_END_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_select_reg_r <= REG_RST;
      pin_analog_config_reg_r <= REG_RST;
      port2_direction_reg_r <= DIR_RST;
      port15_direction_reg_r <= DIR_RST;
      converter_mode_reg_r <= REG_RST;
      reference_control_reg_r <= REG_RST;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      result_r <= '0;
      first_discard_r <= 1'b0;
    end else begin
      channel_select_reg_r <= channel_select_reg_nxt;
      pin_analog_config_reg_r <= pin_analog_config_reg_nxt;
      port2_direction_reg_r <= port2_direction_reg_nxt;
      port15_direction_reg_r <= port15_direction_reg_nxt;
      converter_mode_reg_r <= converter_mode_reg_nxt;
      reference_control_reg_r <= reference_control_reg_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      result_r <= result_nxt;
      first_discard_r <= first_discard_nxt;
    end
  end

  // -------------------------------------------------------------------
  // read data, latched at the address phase so hrdata is a flop
  // -------------------------------------------------------------------
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      case (haddr[7:0])
        CHANSEL_OFF: hrdata_nxt = {24'h0, channel_select_reg_r};
        PINCFG_OFF: hrdata_nxt = {24'h0, pin_analog_config_reg_r};
        P2DIR_OFF: hrdata_nxt = {24'h0, port2_direction_reg_r};
        P15DIR_OFF: hrdata_nxt = {24'h0, port15_direction_reg_r};
        MODE_OFF: hrdata_nxt = {24'h0, core_busy,
                                converter_mode_reg_r[6:0]};
        REFCTL_OFF: hrdata_nxt = {24'h0, reference_control_reg_r};
        RESULT_OFF: hrdata_nxt = 32'(result_r);
        STATUS_OFF: hrdata_nxt = {30'h0, first_discard_r, core_busy};
        IRQSTAT_OFF: hrdata_nxt = {30'h0, irq_stat_r};
        IRQMASK_OFF: hrdata_nxt = {30'h0, irq_mask_r};
        PORTDATA_OFF: hrdata_nxt = {24'h0,
          pin_sync2_r & ~pin_analog_config_reg_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      hrdata_r <= hrdata_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // -------------------------------------------------------------------
  // conversion engine
  // -------------------------------------------------------------------
  adss_core #(.RES_W(RES_W)) u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start_pulse && start_ok),
    .mode(mode_fields),
    .sample(analog_sample),
    .busy(core_busy),
    .done(core_done),
    .result(core_result)
  );

  // analog pin enables and boost are registered copies of the next config values
  logic [7:0] pin_an_r;
  logic boost_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_an_r <= 8'h00;
      boost_r <= 1'b0;
    end else begin
      pin_an_r <= pin_analog_config_reg_nxt;
      boost_r <= reference_control_reg_nxt[REF_BOOST_BIT];
    end
  end

  assign pin_analog_en = pin_an_r;
  assign boost_en = boost_r;
  assign irq = irq_r;
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : adss_top
`default_nettype wire

// *** bench/adss_asserts.sv ***
// Purpose: port-level checks of the converter setup sequencer
// Assumes: one master, hready fed back from hreadyout
// Notes: bound into every adss_top instance
`timescale 1ns/100ps
`default_nettype none
module adss_asserts
  import adss_pkg::*;
#(
  parameter int RES_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] pin_level,
  input wire logic [RES_W-1:0] analog_sample,
  input wire logic irq,
  input wire logic [7:0] pin_analog_en,
  input wire logic boost_en
);
  logic dp_r;
  logic dw_r;
  logic [31:0] da_r;
  logic [7:0] pcfg_r;
  // ---------------------------------------------------------------
  // data-phase tracking
  // ---------------------------------------------------------------
  // keeps the address phase so data-phase values can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_r <= 1'h0;
      dw_r <= 1'h0;
      da_r <= 32'h0;
      pcfg_r <= 8'h00;
    end else begin
      if (hready) begin
        dp_r <= hsel && htrans == HTRANS_NONSEQ;
        dw_r <= hwrite;
        da_r <= haddr;
      end
      if (dp_r && dw_r && da_r == 32'(PINCFG_OFF)) begin
        pcfg_r <= hwdata[7:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(a);
    dp_r && !dw_r && da_r == a;
  endsequence
  sequence s_wr(a);
    dp_r && dw_r && da_r == a;
  endsequence
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("response not okay with zero wait");
  a_rdata_idle: assert property (!(dp_r && !dw_r) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_unmapped_zero: assert property
    (dp_r && !dw_r && da_r > 32'(PORTDATA_OFF) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_chan_upper: assert property
    (s_rd(32'(CHANSEL_OFF)) |-> hrdata[31:4] == 28'h0)
    else $error("channel select upper bits not zero");
  a_analog_zero: assert property
    (s_rd(32'(PORTDATA_OFF)) |-> (hrdata[7:0] & pin_analog_en) == 8'h00)
    else $error("analog pin read back nonzero");
  a_pin_follow: assert property
    (s_wr(32'(PINCFG_OFF)) |-> ##[1:2] pin_analog_en == pcfg_r)
    else $error("pin analog enables not updated");
  a_irq_masked: assert property
    (s_wr(32'(IRQMASK_OFF)) ##0 hwdata == 32'h0 |-> ##2 !irq)
    else $error("irq high with all events masked");
endmodule : adss_asserts

bind adss_top adss_asserts #(.RES_W(RES_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pin_level(pin_level), .analog_sample(analog_sample),
  .irq(irq), .pin_analog_en(pin_analog_en), .boost_en(boost_en)
);
`default_nettype wire

// *** bench/adss_top_tb.sv ***
// Purpose: self-checking bench for the converter setup sequencer
// Assumes: zero wait-state slave, hready fed back from hreadyout
// Notes: every scenario task judges its own results
`timescale 1ns/100ps
`default_nettype none
module adss_top_tb;
  import adss_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] pin_level = 8'hFF;
  logic [11:0] analog_sample = 12'h5A3;
  logic [31:0] hrdata;
  logic [31:0] rd_s;
  logic [7:0] pin_analog_en;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic boost_en;
  logic rdy_s;
  wire hready = hreadyout;
  int mismatches = 0;
  int n_compared = 0;

  adss_top #(.RES_W(12)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_level(pin_level), .analog_sample(analog_sample),
    .irq(irq), .pin_analog_en(pin_analog_en), .boost_en(boost_en)
  );
  // ---------------------------------------------------------------
  // clock, bus sampling and shared tasks
  // ---------------------------------------------------------------
  always #5 hclk = ~hclk;

  // pre-edge copies, so read data never races the slave's update
  always @(posedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end

  task automatic step;
    @(posedge hclk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, m, g, e);
    end
  endtask : chk

  // one single-word transfer; waits on hready, no fixed latency
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    step();
    while (rdy_s !== 1'h1 && n++ < 50) step();
    if (rdy_s !== 1'h1) mismatches++;
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    step();
    while (rdy_s !== 1'h1 && n++ < 100) step();
    if (rdy_s !== 1'h1) mismatches++;
    q = rd_s;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'h1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    logic [31:0] q;
    bus(a, 1'h0, 32'h0, q);
    chk(q, e, m);
  endtask : rdc

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'h1 && n++ < lim) step();
  endtask : wait_irq

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(pin_analog_en, 8'h00, "pin enables at reset");
    chk(boost_en, 1'h0, "boost at reset");
    chk(irq, 1'h0, "irq at reset");
    rdc(P2DIR_OFF, 32'(DIR_RST), "port2 dir reset");
    rdc(P15DIR_OFF, 32'(DIR_RST), "port15 dir reset");
    rdc(MODE_OFF, 32'(REG_RST), "mode reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    wr(CHANSEL_OFF, 32'hFF);
    rdc(CHANSEL_OFF, 32'h0F, "channel upper bits");
    wr(8'h2C, 32'hFFFF_FFFF);
    rdc(8'h2C, 32'h0, "unmapped read");
    wr(PINCFG_OFF, 32'h0F);
    step();
    chk(pin_analog_en, 8'h0F, "pin analog enables");
    rdc(PORTDATA_OFF, 32'hF0, "analog pins read zero");
    $display("test registers done");
  endtask : t_regs

  // one conversion; with skip set, the comparator step is skipped: start and enable in one write
  task automatic t_conv(input logic [2:0] ts, input logic [1:0] lv,
                        input logic skip);
    logic [31:0] m;
    int e;
    int n;
    m = (32'(ts) << MODE_FR_LSB) | (32'(lv) << MODE_LVL_BIT) | 32'h1;
    e = OVERHEAD_CYC + (ts + 1 + lv) * BASE_CONV_CYC;
    wr(MODE_OFF, skip ? 32'h0 : m);
    wr(MODE_OFF, m | 32'h80);
    wait_irq(e + 20, n);
    if (skip) begin
      chk(irq, 1'h0, "dropped result raised event");
    end else begin
      chk(n >= e && n <= e + 5, 1'h1, "conversion length");
      rdc(IRQSTAT_OFF, 32'h1, "end event");
      wr(IRQSTAT_OFF, 32'h1);
      step();
      chk(irq, 1'h0, "irq after clear");
    end
    $display("test conversion ts %0d lv %0d done", ts, lv);
  endtask : t_conv

  task automatic t_hold;
    int n;
    wr(MODE_OFF, 32'h1);
    wr(MODE_OFF, 32'h81);
    wr(REFCTL_OFF, 32'h0);
    step();
    chk(boost_en, 1'h1, "boost held while busy");
    wait_irq(300, n);
    wr(IRQSTAT_OFF, 32'h1);
    $display("test hold done");
  endtask : t_hold

  // a start that the setup must refuse, flagged as an error event
  task automatic t_refuse(input logic [31:0] pc, input logic [31:0] rf,
                          input logic [31:0] m);
    wr(PINCFG_OFF, pc);
    wr(REFCTL_OFF, rf);
    wr(IRQSTAT_OFF, 32'h3);
    wr(MODE_OFF, m & 32'h7F);
    wr(MODE_OFF, m);
    rdc(IRQSTAT_OFF, 32'h2, "start refused");
    chk(irq, 1'h1, "error irq");
    wr(IRQMASK_OFF, 32'h0);
    step();
    chk(irq, 1'h0, "masked irq");
    wr(IRQMASK_OFF, 32'h3);
    wr(IRQSTAT_OFF, 32'h3);
    $display("test refuse %0h done", m);
  endtask : t_refuse

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    step();
    t_reset();
    t_regs();
    wr(PINCFG_OFF, 32'h01);
    wr(CHANSEL_OFF, 32'h0);
    wr(REFCTL_OFF, 32'h1);
    wr(IRQMASK_OFF, 32'h3);
    for (int l = 0; l < 3; l++) begin
      t_conv(3'h0, 2'(l), 1'h0);
      t_conv(3'h7, 2'(l), 1'h0);
    end
    t_conv(3'h2, 2'h0, 1'h1);
    t_hold();
    t_refuse(32'h01, 32'h0, 32'h83);
    t_refuse(32'h01, 32'h0, 32'h85);
    t_refuse(32'h00, 32'h1, 32'h81);
    t_refuse(32'h01, 32'h1, 32'h80);
    wr(REFCTL_OFF, 32'h3);
    wr(PINCFG_OFF, 32'h0);
    wr(CHANSEL_OFF, 32'(AMP_CH));
    t_conv(3'h1, 2'h0, 1'h0);
    close_out();
  end

  // hang guard, far beyond the roughly nine hundred cycles of the run
  initial begin
    #100000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule : adss_top_tb
`default_nettype wire
